//--- tic_route_chop.sv
`timescale 1ns/1ps
// Operation
// RL1 - Bits 5:4 route events to second pin
// RL2 - Bits 1:0 route events to first pin
// RL3 - Code 3 ORs high and low events
// RL4 - Toggle chop after each sample window
// RL5 - Window code N means 2^N samples
// RL6 - Chop register resets to zero
// RL7 - Routing register resets to 0x21
// RL8 - Pins drive event or chop by function
// RL9 - Software never enables chop with enable
// RL10 - High event when result exceeds limit; code raises it only in autonomous mode
// RL11 - Software writes window codes 0 to 11
module tic_route_chop
    import tic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rd_data,
    // Conversion results and threshold events
    input wire logic sample_valid,
    input wire logic [TIC_LIMIT_W-1:0] conv_result,
    input wire logic [TIC_LIMIT_W-1:0] high_limit,
    input wire logic result_is_signed,
    input wire logic autonomous_mode,
    input wire logic low_threshold_event,
    // Pin function selections
    input wire logic [2:0] first_pin_function,
    input wire logic [2:0] second_pin_function,
    // Routed events and chop state
    output logic first_pin_event_output,
    output logic second_pin_event_output,
    output logic high_threshold_event,
    output logic chop_out,
    // General purpose pins
    output logic first_general_pin_o,
    output logic first_general_pin_oe_n,
    output logic second_general_pin_o,
    output logic second_general_pin_oe_n
);
    typedef struct packed {
        logic [1:0] sel1;
        logic [1:0] sel0;
        logic [3:0] win;
        logic hi_evt;
        logic ev0;
        logic ev1;
        logic chop;
        logic pin0;
        logic pin0_oe_n;
        logic pin1;
        logic pin1_oe_n;
        logic [7:0] rd;
    } tic_top_s;

    tic_top_s st_r;
    tic_top_s st_nxt;
    tic_chop_if chop_bus ();

    // Pick the routed event for one selection code
    function automatic logic route(input logic [1:0] sel, input logic lo,
                                   input logic hi);
        case (sel)
            TIC_SEL_LOW: route = lo;
            TIC_SEL_HIGH: route = hi;
            TIC_SEL_BOTH: route = lo | hi; // see RL3
            default: route = 1'b0;
        endcase
    endfunction

    // Compare in the result's own format
    function automatic logic exceeds(input logic [TIC_LIMIT_W-1:0] res,
                                     input logic [TIC_LIMIT_W-1:0] lim,
                                     input logic sgn);
        if (sgn) begin
            exceeds = $signed(res) > $signed(lim);
        end else begin
            exceeds = res > lim;
        end
    endfunction

    // Pin drive: only event or chop functions own the pin
    function automatic logic [1:0] pin_drive(input logic [2:0] func,
                                             input logic ev,
                                             input logic ch);
        if (func == TIC_FUNC_EVENT) begin
            pin_drive = {ev, 1'b0}; // see RL8
        end else if (func == TIC_FUNC_CHOP) begin
            pin_drive = {ch, 1'b0}; // see RL8
        end else begin
            pin_drive = 2'b01;
        end
    endfunction

    // Chop generator counts the same conversion strobe
    assign chop_bus.sample_strobe = sample_valid;
    assign chop_bus.window_code = st_r.win;

    tic_chop_gen u_chop (
        .ref_clk(ref_clk),
        .reset(reset),
        .chop(chop_bus.gen)
    );

    // Next state: registers, events, pins and read data
    always_comb begin
        st_nxt = st_r;
        // Reserved bits are dropped on write and read back as zero
        if (reg_wr_en) begin
            if (reg_addr == TIC_ADDR_ROUTE) begin
                st_nxt.sel1 = reg_wdata[TIC_SEL1_HI:TIC_SEL1_LO]; // see RL1
                st_nxt.sel0 = reg_wdata[TIC_SEL0_HI:TIC_SEL0_LO]; // see RL2
            end else if (reg_addr == TIC_ADDR_CHOP) begin
                st_nxt.win = reg_wdata[TIC_WIN_HI:TIC_WIN_LO]; // see RL4
            end
        end
        // High event holds from one sample to the next
        if (sample_valid) begin
            st_nxt.hi_evt = autonomous_mode &&
                exceeds(conv_result, high_limit, result_is_signed); // see RL10
        end
        st_nxt.ev0 = route(st_r.sel0, low_threshold_event,
                           st_r.hi_evt); // see RL2
        st_nxt.ev1 = route(st_r.sel1, low_threshold_event,
                           st_r.hi_evt); // see RL1
        st_nxt.chop = chop_bus.chop_state;
        {st_nxt.pin0, st_nxt.pin0_oe_n} =
            pin_drive(first_pin_function, st_r.ev0, st_r.chop);
        {st_nxt.pin1, st_nxt.pin1_oe_n} =
            pin_drive(second_pin_function, st_r.ev1, st_r.chop);
        // Read data lags the address by one cycle
        if (reg_addr == TIC_ADDR_ROUTE) begin
            st_nxt.rd = '0;
            st_nxt.rd[TIC_SEL1_HI:TIC_SEL1_LO] = st_r.sel1;
            st_nxt.rd[TIC_SEL0_HI:TIC_SEL0_LO] = st_r.sel0;
        end else if (reg_addr == TIC_ADDR_CHOP) begin
            st_nxt.rd = '0;
            st_nxt.rd[TIC_WIN_HI:TIC_WIN_LO] = st_r.win;
        end else begin
            st_nxt.rd = '0;
        end
    end

    // State register with documented defaults
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.sel1 <= TIC_ROUTE_RESET[TIC_SEL1_HI:TIC_SEL1_LO]; // see RL7
            st_r.sel0 <= TIC_ROUTE_RESET[TIC_SEL0_HI:TIC_SEL0_LO]; // see RL7
            st_r.win <= TIC_CHOP_RESET[TIC_WIN_HI:TIC_WIN_LO]; // see RL6
            st_r.pin0_oe_n <= 1'b1;
            st_r.pin1_oe_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign reg_rd_data = st_r.rd;
    assign first_pin_event_output = st_r.ev0;
    assign second_pin_event_output = st_r.ev1;
    assign high_threshold_event = st_r.hi_evt;
    assign chop_out = st_r.chop;
    assign first_general_pin_o = st_r.pin0;
    assign first_general_pin_oe_n = st_r.pin0_oe_n;
    assign second_general_pin_o = st_r.pin1;
    assign second_general_pin_oe_n = st_r.pin1_oe_n;

    property p_second_none;
        @(posedge ref_clk) disable iff (reset)
        st_r.sel1 == TIC_SEL_NONE |=> !second_pin_event_output;
    endproperty
    a_second_none: assert property (p_second_none) // see RL1
        else $error("second pin event shown with no selection");

    property p_second_high;
        @(posedge ref_clk) disable iff (reset)
        st_r.sel1 == TIC_SEL_HIGH
        |=> second_pin_event_output == $past(st_r.hi_evt);
    endproperty
    a_second_high: assert property (p_second_high) // see RL1
        else $error("second pin does not follow high event");

    property p_first_low;
        @(posedge ref_clk) disable iff (reset)
        st_r.sel0 == TIC_SEL_LOW
        |=> first_pin_event_output == $past(low_threshold_event);
    endproperty
    a_first_low: assert property (p_first_low) // see RL2
        else $error("first pin does not follow low event");

    property p_both;
        @(posedge ref_clk) disable iff (reset)
        st_r.sel0 == TIC_SEL_BOTH |=> first_pin_event_output ==
            ($past(low_threshold_event) | $past(st_r.hi_evt));
    endproperty
    a_both: assert property (p_both) // see RL3
        else $error("either-event routing is not an OR");

    property p_reset_vals;
        @(posedge ref_clk) disable iff (reset)
        $past(reset) |-> st_r.sel0 == TIC_SEL_LOW &&
            st_r.sel1 == TIC_SEL_HIGH && st_r.win == 4'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals) // see RL7
        else $error("register defaults wrong after reset");

    property p_pin_release;
        @(posedge ref_clk) disable iff (reset)
        first_pin_function != TIC_FUNC_EVENT &&
        first_pin_function != TIC_FUNC_CHOP |=> first_general_pin_oe_n;
    endproperty
    a_pin_release: assert property (p_pin_release) // see RL8
        else $error("first pin driven by a foreign function");

    property p_pin_chop;
        @(posedge ref_clk) disable iff (reset)
        second_pin_function == TIC_FUNC_CHOP |=> !second_general_pin_oe_n
            && second_general_pin_o == $past(st_r.chop);
    endproperty
    a_pin_chop: assert property (p_pin_chop) // see RL8
        else $error("second pin does not carry chop");

    property p_high_event;
        @(posedge ref_clk) disable iff (reset)
        sample_valid && autonomous_mode && !result_is_signed &&
        conv_result > high_limit |=> high_threshold_event;
    endproperty
    a_high_event: assert property (p_high_event) // see RL10
        else $error("high event missed on an over-limit sample");
endmodule

//--- tic_pkg.sv
package tic_pkg;
    // Register offsets on the local register port
    localparam logic [7:0] TIC_ADDR_ROUTE = 8'h25;
    localparam logic [7:0] TIC_ADDR_CHOP = 8'h26;
    // Reset values
    localparam logic [7:0] TIC_ROUTE_RESET = 8'h21;
    localparam logic [7:0] TIC_CHOP_RESET = 8'h00;
    // Field positions in the routing register
    localparam int TIC_SEL1_HI = 5;
    localparam int TIC_SEL1_LO = 4;
    localparam int TIC_SEL0_HI = 1;
    localparam int TIC_SEL0_LO = 0;
    // Field position in the chop register
    localparam int TIC_WIN_HI = 3;
    localparam int TIC_WIN_LO = 0;
    // Event selection codes
    localparam logic [1:0] TIC_SEL_NONE = 2'h0;
    localparam logic [1:0] TIC_SEL_LOW = 2'h1;
    localparam logic [1:0] TIC_SEL_HIGH = 2'h2;
    localparam logic [1:0] TIC_SEL_BOTH = 2'h3;
    // Pin function codes that this block serves
    localparam logic [2:0] TIC_FUNC_EVENT = 3'h1;
    localparam logic [2:0] TIC_FUNC_CHOP = 3'h4;
    // Largest legal window code and sample counter width
    localparam logic [3:0] TIC_WIN_MAX = 4'hB;
    localparam int TIC_CNT_W = 11;
    localparam int TIC_LIMIT_W = 12;
    typedef logic [TIC_CNT_W-1:0] tic_cnt_t;
endpackage

//--- tic_chop_if.sv
`timescale 1ns/1ps
interface tic_chop_if;
    logic sample_strobe;
    logic [3:0] window_code;
    logic chop_state;
    // Generator side
    modport gen (
        input sample_strobe,
        input window_code,
        output chop_state
    );
    // Controller side
    modport ctl (
        output sample_strobe,
        output window_code,
        input chop_state
    );
endinterface

//--- tic_chop_gen.sv
`timescale 1ns/1ps
module tic_chop_gen
    import tic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control and chop state
    tic_chop_if.gen chop
);
    typedef struct packed {
        tic_cnt_t cnt;
        logic state;
    } tic_chop_s;

    tic_chop_s st_r;
    tic_chop_s st_nxt;

    // Last count of a window: codes above the maximum clamp to it
    function automatic tic_cnt_t win_last(input logic [3:0] code);
        logic [3:0] c;
        c = (code > TIC_WIN_MAX) ? TIC_WIN_MAX : code; // see RL5
        win_last = tic_cnt_t'((TIC_CNT_W+1)'(1) << c) - tic_cnt_t'(1);
    endfunction

    // Count samples, toggle at the end of each window
    always_comb begin
        st_nxt = st_r;
        if (chop.sample_strobe) begin
            if (st_r.cnt >= win_last(chop.window_code)) begin // see RL4
                st_nxt.cnt = '0;
                st_nxt.state = ~st_r.state;
            end else begin
                st_nxt.cnt = st_r.cnt + tic_cnt_t'(1);
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign chop.chop_state = st_r.state;

    property p_stable_between;
        @(posedge ref_clk) disable iff (reset)
        !chop.sample_strobe |=> $stable(chop.chop_state);
    endproperty
    a_stable_between: assert property (p_stable_between) // see RL4
        else $error("chop state moved without a sample");

    property p_window_end;
        @(posedge ref_clk) disable iff (reset)
        chop.sample_strobe && st_r.cnt == win_last(chop.window_code)
        |=> chop.chop_state != $past(chop.chop_state);
    endproperty
    a_window_end: assert property (p_window_end) // see RL4
        else $error("chop state did not toggle at window end");

    property p_code_one;
        @(posedge ref_clk) disable iff (reset)
        chop.window_code == 4'h1 && st_r.cnt == '0 && chop.sample_strobe
        |=> $stable(chop.chop_state);
    endproperty
    a_code_one: assert property (p_code_one) // see RL5
        else $error("two-sample window toggled after one sample");

    // Longest window must hold for all 2048 samples before it toggles
    property p_code_max;
        @(posedge ref_clk) disable iff (reset)
        chop.window_code == TIC_WIN_MAX && chop.sample_strobe &&
        st_r.cnt < 11'h7FF |=> $stable(chop.chop_state);
    endproperty
    a_code_max: assert property (p_code_max) // see RL5
        else $error("longest window toggled before 2048 samples");
endmodule

//--- tic_host_model.sv
`timescale 1ns/1ps
// Host interrupt input and amplifier chop input seen through the pins
module tic_host_model (
    // Clock
    input wire logic ref_clk,
    // Pins as driven by the block
    input wire logic pin0_o,
    input wire logic pin0_oe_n,
    input wire logic pin1_o,
    input wire logic pin1_oe_n,
    // Levels as the host sees them
    output logic wire0,
    output logic wire1
);
    logic last0_r = 1'b0;
    logic last1_r = 1'b0;
    // Remember the last driven level of each pin
    always @(posedge ref_clk) begin
        if (!pin0_oe_n) last0_r <= pin0_o;
        if (!pin1_oe_n) last1_r <= pin1_o;
    end
    // A released pin has no keeper, so show the opposite of the last level
    assign wire0 = pin0_oe_n ? ~last0_r : pin0_o;
    assign wire1 = pin1_oe_n ? ~last1_r : pin1_o;
endmodule

//--- threshold_irq_routing_and_chop_tb.sv
`timescale 1ns/1ps
module threshold_irq_routing_and_chop_tb;
    import tic_pkg::*;
    typedef struct {int kind; logic [15:0] exp;} tic_note_s;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr_en = 1'b0;
    logic sample_valid = 1'b0;
    logic result_is_signed = 1'b0;
    logic autonomous_mode = 1'b0;
    logic low_threshold_event = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rd_data;
    logic [TIC_LIMIT_W-1:0] conv_result = 12'h000;
    logic [TIC_LIMIT_W-1:0] high_limit = 12'h000;
    logic [2:0] first_pin_function = 3'h1;
    logic [2:0] second_pin_function = 3'h0;
    logic ev0, ev1, hi_ev, chop_out, p0_o, p0_oe_n, p1_o, p1_oe_n;
    logic wire0, wire1, hi, e0, e1, oe1, p1e, last;
    logic last1_e = 1'b0;
    logic look = 1'b0;
    logic [15:0] meas = 16'h0000;
    logic [31:0] rnd = 32'h0000_8d79;
    logic [2:0] fn_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    int err_count = 0;
    int tests_run = 0;
    int n;
    tic_note_s notes[$];
    tic_note_s cur;

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    tic_route_chop uut (
        .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_data(reg_rd_data), .sample_valid(sample_valid),
        .conv_result(conv_result), .high_limit(high_limit),
        .result_is_signed(result_is_signed),
        .autonomous_mode(autonomous_mode),
        .low_threshold_event(low_threshold_event),
        .first_pin_function(first_pin_function),
        .second_pin_function(second_pin_function),
        .first_pin_event_output(ev0), .second_pin_event_output(ev1),
        .high_threshold_event(hi_ev), .chop_out(chop_out),
        .first_general_pin_o(p0_o), .first_general_pin_oe_n(p0_oe_n),
        .second_general_pin_o(p1_o), .second_general_pin_oe_n(p1_oe_n)
    );

    tic_host_model host (
        .ref_clk(ref_clk), .pin0_o(p0_o), .pin0_oe_n(p0_oe_n),
        .pin1_o(p1_o), .pin1_oe_n(p1_oe_n), .wire0(wire0), .wire1(wire1)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic final_report;
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Register read data
    task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD reg_rd_data expected %h seen %h", e, g);
            err_count++;
        end
    endtask

    // Routed events, pin drives and host-side levels
    task automatic cmp_pins(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD pins expected %h seen %h", e, g);
            err_count++;
        end
    endtask

    // Measured chop window length in samples
    task automatic cmp_len(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD chop_len expected %h seen %h", e, g);
            err_count++;
        end
    endtask

    // Hand an expectation to the watcher, which looks at the next edge
    task automatic note(input int k, input logic [15:0] e);
        notes.push_back('{k, e});
        look <= 1'b1;
        @(posedge ref_clk);
        look <= 1'b0;
    endtask

    // Single-byte write; a pending sample strobe is dropped here
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
    endtask

    // Read data shows one cycle after the address is presented
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        @(posedge ref_clk);
        note(0, {8'h00, e});
    endtask

    // Stream samples and time the third pin toggle after a code change
    task automatic chop_len(input logic [3:0] c);
        wr(TIC_ADDR_CHOP, {4'h0, c});
        sample_valid <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            last = wire0;
            n = 0;
            while (wire0 === last && n < 5000) begin
                @(negedge ref_clk);
                n++;
            end
            if (n >= 5000) begin
                err_count++;
                final_report();
            end
        end
        meas = 16'(n);
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        note(2, 16'h0001 << c);
    endtask

    // Watcher: pairs each appearing result with the oldest note
    always @(posedge ref_clk) begin
        if (look) begin
            cur = notes.pop_front();
            case (cur.kind)
                0: cmp_rd(cur.exp[7:0], reg_rd_data);
                1: cmp_pins(cur.exp, {7'h00, wire1, chop_out, p1_o, p1_oe_n,
                    p0_oe_n, wire0, hi_ev, ev1, ev0});
                default: cmp_len(cur.exp, meas);
            endcase
        end
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rd(TIC_ADDR_ROUTE, TIC_ROUTE_RESET);
        rd(TIC_ADDR_CHOP, TIC_CHOP_RESET);
        wr(TIC_ADDR_ROUTE, 8'hff);
        rd(TIC_ADDR_ROUTE, 8'h33);
        wr(TIC_ADDR_CHOP, 8'hff);
        rd(TIC_ADDR_CHOP, 8'h0f);
        wr(8'h40, 8'h5a);
        rd(8'h40, 8'h00);
        rd(TIC_ADDR_ROUTE, 8'h33);
        // Every pair of selection codes, random results and limits
        for (int i = 0; i < 32; i++) begin
            rnd = lfsr(rnd);
            @(posedge ref_clk);
            sample_valid <= 1'b1;
            conv_result <= rnd[11:0];
            high_limit <= rnd[23:12];
            result_is_signed <= rnd[24];
            autonomous_mode <= rnd[25];
            low_threshold_event <= rnd[26];
            second_pin_function <= fn_tab[rnd[28:27]];
            hi = rnd[25] && (rnd[24] ? $signed(rnd[11:0]) >
                 $signed(rnd[23:12]) : rnd[11:0] > rnd[23:12]);
            e0 = (i[0] & rnd[26]) | (i[1] & hi);
            e1 = (i[2] & rnd[26]) | (i[3] & hi);
            oe1 = !(fn_tab[rnd[28:27]] == 3'h1 || fn_tab[rnd[28:27]] == 3'h4);
            // Chop stays low here: far fewer samples than one window
            p1e = (fn_tab[rnd[28:27]] == TIC_FUNC_EVENT) && e1;
            wr(TIC_ADDR_ROUTE, {2'b00, i[3:2], 2'b00, i[1:0]});
            repeat (4) @(posedge ref_clk);
            note(1, {7'h00, (oe1 ? ~last1_e : p1e), 1'b0, p1e, oe1, 1'b0,
                     e0, hi, e1, e0});
            // A released pin shows the inverse of its last driven level
            if (!oe1) last1_e = p1e;
        end
        // Fresh reset so the sample counter starts from zero
        reset <= 1'b1;
        first_pin_function <= TIC_FUNC_CHOP;
        second_pin_function <= 3'h0;
        @(posedge ref_clk);
        reset <= 1'b0;
        chop_len(4'h0);
        chop_len(4'h1);
        chop_len(4'h5);
        chop_len(4'hb);
        repeat (2) @(posedge ref_clk);
        final_report();
    end
endmodule
